//--- cxh_coex_host.sv
// Summary of operation
// - first priority bit within 100 us
// - direction follows priority, held until changed
// - second priority bit only in two-bit mode
// - direction steady through slot if unchanged
// - direction change only after last data
// - request drops within 25 us after data
// - first slot 8 to 600 us after request
// - every slot lasts exactly 625 us
// - activity starts 20-499 us after priority
// - priority drops promptly after activity ends
`timescale 1ns/100ps
`default_nettype none

module cxh_coex_host
    import cxh_pkg::*;
#(
    parameter int unsigned SLOTS_W = SLOT_CNT_W
)
(
    input  wire logic               clk_sys,
    input  wire logic               reset_n,
    input  wire logic               start,
    input  wire logic               activity_scheme,
    input  wire logic               two_bit_priority,
    input  wire logic [1:0]         priority_bits,
    input  wire logic               first_dir_tx,
    input  wire logic               next_dir_tx,
    input  wire logic [SLOTS_W-1:0] slot_count,
    output logic                    ready,
    output var  logic               slot_start,
    output var  logic               slot_granted,
    output var  logic               wlan_busy_seen,
    output var  logic               done,
    output var  logic               peer_radio_request,
    output var  logic               peer_radio_state_line,
    output var  logic               peer_radio_priority,
    input  wire logic               peer_slot_grant_n,
    input  wire logic               local_wlan_busy
);

    typedef struct packed {
        // sequence position and slots still to run
        cxh_state_t         state;
        logic [SLOTS_W-1:0] slots_left;
        // settings latched at start
        logic               two_bit;
        logic [1:0]         prio;
        logic               dir_tx;
        // link pins
        logic               req;
        logic               stat;
        logic               pri;
        // user-facing flags
        logic               slot_start;
        logic               granted;
        logic               busy_seen;
        logic               done;
    } cxh_host_st_t;

    cxh_host_st_t r;
    cxh_host_st_t next_r;

    // local reset copy and timer hookup
    logic [1:0]       rst_sync;
    logic             rst_n;
    logic             tick;
    logic             tmr_load;
    logic [TMR_W-1:0] tmr_us;
    logic             tmr_exp;

    // reset release through two flip-flops
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            rst_sync <= 2'b00;
        else
            rst_sync <= {rst_sync[0], 1'b1};
    end

    // the rest of the block resets from this copy
    assign rst_n = rst_sync[1];

    // microsecond time base and phase timer
    cxh_us_tick u_tick (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tick    (tick)
    );

    // one-shot phase timer, loaded once per phase
    cxh_us_timer u_timer (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .tick    (tick),
        .load    (tmr_load),
        .load_us (tmr_us),
        .expired (tmr_exp)
    );

    // sequence of request, priority, direction and slots
    always_comb
    begin
        next_r = r;
        next_r.slot_start = 1'b0;
        next_r.done = 1'b0;
        tmr_load = 1'b0;
        tmr_us = '0;
        case (r.state)
            // wait for start, latch settings, open the link
            CXH_IDLE:
            begin
                if (start)
                begin
                    next_r.two_bit = two_bit_priority;
                    next_r.prio = priority_bits;
                    next_r.dir_tx = first_dir_tx;
                    next_r.granted = 1'b0;
                    next_r.slots_left = (slot_count == '0) ? SLOTS_W'(1)
                                                           : slot_count;
                    tmr_load = 1'b1;
                    if (activity_scheme)
                    begin
                        // sample busy before the priority rise
                        next_r.busy_seen = local_wlan_busy;
                        next_r.pri = 1'b1;
                        tmr_us = ACT_LEAD_US;
                        next_r.state = CXH_ACT_LEAD;
                    end
                    else
                    begin
                        // request scheme: raise request, first bit
                        next_r.req = 1'b1;
                        next_r.stat = priority_bits[0];
                        tmr_us = PRIO_STEP_US;
                        next_r.state = CXH_PRIO0;
                    end
                end
            end

            // first priority bit on the state line
            CXH_PRIO0:
            begin
                if (tmr_exp)
                begin
                    tmr_load = 1'b1;
                    if (r.two_bit)
                    begin
                        // two-bit mode: second bit before direction
                        next_r.stat = r.prio[1];
                        tmr_us = PRIO_STEP_US;
                        next_r.state = CXH_PRIO1;
                    end
                    else
                    begin
                        next_r.stat = r.dir_tx;
                        tmr_us = DIR_ONE_US;
                        next_r.state = CXH_DIR_WAIT;
                    end
                end
            end

            // second priority bit, two-bit mode only
            CXH_PRIO1:
            begin
                if (tmr_exp)
                begin
                    next_r.stat = r.dir_tx;
                    tmr_load = 1'b1;
                    tmr_us = DIR_TWO_US;
                    next_r.state = CXH_DIR_WAIT;
                end
            end

            // direction shown, waiting for the next boundary
            CXH_DIR_WAIT, CXH_SLOT_TAIL:
            begin
                if (tmr_exp)
                begin
                    // slot boundary: grant is sampled here
                    next_r.slot_start = 1'b1;
                    next_r.granted = ~peer_slot_grant_n;
                    tmr_load = 1'b1;
                    tmr_us = DATA_US;
                    next_r.state = CXH_SLOT_DATA;
                end
            end

            // data part of a slot, state line held
            CXH_SLOT_DATA:
            begin
                if (tmr_exp)
                begin
                    tmr_load = 1'b1;
                    next_r.slots_left = r.slots_left - SLOTS_W'(1);
                    if (r.slots_left == SLOTS_W'(1))
                    begin
                        // last slot: hold request for the drop delay
                        tmr_us = REQ_DROP_US;
                        next_r.state = CXH_REQ_DROP;
                    end
                    else
                    begin
                        // line moves only after the last data bit
                        next_r.dir_tx = next_dir_tx;
                        next_r.stat = next_dir_tx;
                        tmr_us = TAIL_US;
                        next_r.state = CXH_SLOT_TAIL;
                    end
                end
            end

            // drop request and state line, report done
            CXH_REQ_DROP:
            begin
                if (tmr_exp)
                begin
                    next_r.req = 1'b0;
                    next_r.stat = 1'b0;
                    next_r.done = 1'b1;
                    next_r.state = CXH_IDLE;
                end
            end

            // priority raised, lead time before activity
            CXH_ACT_LEAD:
            begin
                if (tmr_exp)
                begin
                    next_r.slot_start = 1'b1;
                    next_r.busy_seen = local_wlan_busy;
                    tmr_load = 1'b1;
                    tmr_us = SLOT_US;
                    next_r.state = CXH_ACT_RUN;
                end
            end

            // activity slots, priority held throughout
            CXH_ACT_RUN:
            begin
                if (tmr_exp)
                begin
                    next_r.slots_left = r.slots_left - SLOTS_W'(1);
                    if (r.slots_left == SLOTS_W'(1))
                    begin
                        next_r.pri = 1'b0;
                        next_r.done = 1'b1;
                        next_r.state = CXH_IDLE;
                    end
                    else
                    begin
                        // more slots: mark the next boundary
                        next_r.slot_start = 1'b1;
                        next_r.busy_seen = local_wlan_busy;
                        tmr_load = 1'b1;
                        tmr_us = SLOT_US;
                    end
                end
            end

            // stray code: back to a clean idle
            default:
            begin
                next_r = '0;
                next_r.state = CXH_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            r <= '0;
            r.state <= CXH_IDLE;
        end
        else
        begin
            r <= next_r;
        end
    end

    // outputs to the user side
    assign ready = (r.state == CXH_IDLE);
    assign slot_start = r.slot_start;
    assign slot_granted = r.granted;
    assign wlan_busy_seen = r.busy_seen;
    assign done = r.done;

    // outputs to the link pins
    assign peer_radio_request = r.req;
    assign peer_radio_state_line = r.stat;
    assign peer_radio_priority = r.pri;

endmodule

`default_nettype wire

//--- cxh_pkg.sv
`default_nettype none

package cxh_pkg;

    // clock rate and microsecond tick
    localparam int unsigned CLK_HZ       = 20_000_000;
    localparam int unsigned HZ_PER_MHZ   = 1_000_000;
    localparam int unsigned CYC_PER_US   = CLK_HZ / HZ_PER_MHZ;

    // interval timer width in microseconds
    localparam int unsigned TMR_W        = 10;

    // slot count width
    localparam int unsigned SLOT_CNT_W   = 8;

    // request scheme timing, microseconds
    localparam logic [9:0] PRIO_STEP_US  = 10'd10;  // per priority bit
    localparam logic [9:0] FIRST_SLOT_US = 10'd600; // request rise to slot
    localparam logic [9:0] SLOT_US       = 10'd625; // fixed slot length
    localparam logic [9:0] DATA_US       = 10'd366; // data part of slot
    localparam logic [9:0] REQ_DROP_US   = 10'd15;  // last bit to drop

    // activity scheme timing, microseconds
    localparam logic [9:0] ACT_LEAD_US   = 10'd50;  // priority to activity

    // derived phase lengths
    localparam logic [9:0] DIR_ONE_US    = FIRST_SLOT_US - PRIO_STEP_US;
    localparam logic [9:0] DIR_TWO_US    = FIRST_SLOT_US - PRIO_STEP_US
                                           - PRIO_STEP_US;
    localparam logic [9:0] TAIL_US       = SLOT_US - DATA_US;

    // controller sequence states
    typedef enum logic [3:0] {
        CXH_IDLE,
        CXH_PRIO0,
        CXH_PRIO1,
        CXH_DIR_WAIT,
        CXH_SLOT_DATA,
        CXH_SLOT_TAIL,
        CXH_REQ_DROP,
        CXH_ACT_LEAD,
        CXH_ACT_RUN
    } cxh_state_t;

endpackage

`default_nettype wire

//--- cxh_us_tick.sv
`timescale 1ns/100ps
`default_nettype none

module cxh_us_tick
    import cxh_pkg::*;
#(
    parameter int unsigned DIV = CYC_PER_US
)
(
    input  wire logic clk_sys,
    input  wire logic rst_n,
    output var  logic tick
);

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } cxh_tick_st_t;

    cxh_tick_st_t r;
    cxh_tick_st_t next_r;

    localparam logic [15:0] LAST = 16'(DIV - 1);

    // free divider, one pulse per microsecond
    always_comb
    begin
        next_r = r;
        next_r.tick = 1'b0;
        if (r.cnt == LAST)
        begin
            next_r.cnt = 16'h0000;
            next_r.tick = 1'b1;
        end
        else
        begin
            next_r.cnt = r.cnt + 16'h0001;
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            r <= '0;
        else
            r <= next_r;
    end

    assign tick = r.tick;

endmodule

`default_nettype wire

//--- cxh_us_timer.sv
`timescale 1ns/100ps
`default_nettype none

module cxh_us_timer
    import cxh_pkg::*;
#(
    parameter int unsigned W = TMR_W
)
(
    input  wire logic         clk_sys,
    input  wire logic         rst_n,
    input  wire logic         tick,
    input  wire logic         load,
    input  wire logic [W-1:0] load_us,
    output var  logic         expired
);

    typedef struct packed {
        logic [W-1:0] cnt;
        logic         run;
        logic         expired;
    } cxh_tmr_st_t;

    cxh_tmr_st_t r;
    cxh_tmr_st_t next_r;

    // microsecond down counter, one pulse at zero
    always_comb
    begin
        next_r = r;
        next_r.expired = 1'b0;
        if (load)
        begin
            // a tick landing with the load is the first one counted, so
            // the first phase never overruns its length
            next_r.cnt = tick ? load_us - W'(1) : load_us;
            next_r.run = 1'b1;
        end
        else if (r.run && tick)
        begin
            if (r.cnt <= W'(1))
            begin
                next_r.run = 1'b0;
                next_r.cnt = '0;
                next_r.expired = 1'b1;
            end
            else
            begin
                next_r.cnt = r.cnt - W'(1);
            end
        end
    end

    // state register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
            r <= '0;
        else
            r <= next_r;
    end

    assign expired = r.expired;

endmodule

`default_nettype wire

//--- cxh_coex_host_checker.sv
`timescale 1ns/100ps
`default_nettype none

module cxh_coex_host_checker
    import cxh_pkg::*;
#(
    parameter int unsigned SLOTS_W = SLOT_CNT_W
)
(
    input wire logic               clk_sys,
    input wire logic               reset_n,
    input wire logic               start,
    input wire logic               activity_scheme,
    input wire logic               two_bit_priority,
    input wire logic [1:0]         priority_bits,
    input wire logic               first_dir_tx,
    input wire logic               next_dir_tx,
    input wire logic [SLOTS_W-1:0] slot_count,
    input wire logic               ready,
    input wire logic               slot_start,
    input wire logic               slot_granted,
    input wire logic               wlan_busy_seen,
    input wire logic               done,
    input wire logic               peer_radio_request,
    input wire logic               peer_radio_state_line,
    input wire logic               peer_radio_priority,
    input wire logic               peer_slot_grant_n,
    input wire logic               local_wlan_busy
);
    localparam int SLOT_CYC = 12500;
    int         gap;
    int         lnk;
    logic       first;
    logic [4:0] cfg;

    // cycles since slot start, link time, settings taken at start
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gap   <= 0;
            lnk   <= 0;
            first <= 1'b0;
            cfg   <= 5'h00;
        end
        else
        begin
            gap <= slot_start ? 1 : gap + 1;
            lnk <= (peer_radio_request || peer_radio_priority) ? lnk + 1 : 0;
            if (ready && start)
            begin
                first <= 1'b1;
                cfg   <= {activity_scheme, two_bit_priority, first_dir_tx,
                          priority_bits};
            end
            else if (slot_start)
                first <= 1'b0;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    sequence s_req_up;
        $rose(peer_radio_request);
    endsequence
    sequence s_first_slot;
        slot_start && first;
    endsequence

    a_prio0_first: assert property (s_req_up |->
        peer_radio_state_line == cfg[0]) else $error("priority bit 0 wrong");
    a_prio1_step: assert property (!cfg[4] && lnk == 300 |->
        peer_radio_state_line == (cfg[3] ? cfg[1] : cfg[2]))
        else $error("second phase value wrong");
    a_first_slot: assert property (s_first_slot |->
        cfg[4] || lnk inside {[160:12000]}) else $error("first slot late");
    a_act_lead: assert property (s_first_slot |->
        !cfg[4] || lnk inside {[400:9980]}) else $error("activity lead");
    a_slot_len: assert property (slot_start && !first |->
        gap == SLOT_CYC) else $error("slot length wrong");
    a_state_steady: assert property (peer_radio_request &&
        !first && gap inside {[2:7300]} |-> $stable(peer_radio_state_line))
        else $error("state moved during data");
    a_req_drop: assert property ($fell(peer_radio_request) |->
        done && gap inside {[7320:7820]}) else $error("request drop time");
    a_prio_drop: assert property ($fell(peer_radio_priority) |->
        done && gap inside {[12480:12520]}) else $error("priority drop");
endmodule

bind cxh_coex_host cxh_coex_host_checker #(.SLOTS_W(SLOTS_W)) i_chk (.*);

`default_nettype wire

//--- cxh_arbiter_model.sv
`timescale 1ns/100ps
`default_nettype none

module cxh_arbiter_model
    import cxh_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic reset_n,
    input  wire logic peer_radio_request,
    input  wire logic peer_radio_state_line,
    input  wire logic peer_radio_priority,
    input  wire logic slow,
    input  wire logic busy_hold,
    output var  logic peer_slot_grant_n,
    output var  logic local_wlan_busy
);
    int         div;
    int         wait_us;
    logic [2:0] req_s, st_s, pri_s;

    // sync pins, count us ticks, decide grant and busy
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {req_s, st_s, pri_s} <= 9'h000;
            div                  <= 0;
            wait_us              <= -1;
            peer_slot_grant_n    <= 1'b1;
            local_wlan_busy      <= 1'b1;
        end
        else
        begin
            req_s <= {req_s[1:0], peer_radio_request};
            st_s  <= {st_s[1:0], peer_radio_state_line};
            pri_s <= {pri_s[1:0], peer_radio_priority};
            div   <= (div == CYC_PER_US - 1) ? 0 : div + 1;
            if (div == 0 && wait_us > 0)
                wait_us <= wait_us - 1;
            if (req_s[1] && !req_s[2])
                wait_us <= slow ? 530 : 32;
            else if (req_s[1] && st_s[1] && !st_s[2] && !peer_slot_grant_n)
            begin
                peer_slot_grant_n <= 1'b1;
                wait_us           <= slow ? 500 : 2;
            end
            else if (pri_s[1] && !pri_s[2])
                wait_us <= 5;
            else if (wait_us == 0)
            begin
                if (pri_s[1])
                    local_wlan_busy <= busy_hold;
                else
                    peer_slot_grant_n <= 1'b0;
                wait_us <= -1;
            end
            if (!req_s[1])
                peer_slot_grant_n <= 1'b1;
            if (!pri_s[1])
                local_wlan_busy <= 1'b1;
        end
    end
endmodule

`default_nettype wire

//--- test_cxh_coex_host.sv
`timescale 1ns/100ps
`default_nettype none

module test_cxh_coex_host
    import cxh_pkg::*;
;
    logic                  clk_sys, reset_n, start, activity_scheme;
    logic                  two_bit_priority, first_dir_tx, next_dir_tx;
    logic [1:0]            priority_bits;
    logic [SLOT_CNT_W-1:0] slot_count;
    logic                  ready, slot_start, slot_granted, wlan_busy_seen;
    logic                  done, peer_radio_request, peer_radio_state_line;
    logic                  peer_radio_priority, peer_slot_grant_n;
    logic                  local_wlan_busy, slow, busy_hold;
    int                    seed, cycles, bad_count, checked;

    cxh_coex_host i_dut (.*);
    cxh_arbiter_model i_peer (.*);

    // clock
    always #25 clk_sys = ~clk_sys;

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one sequence against the bench model
    task automatic run(input logic act, input logic two, input logic f,
                       input logic n, input int slots, input logic sl,
                       input logic hd);
        int         cyc;
        int         nseen;
        int         ns;
        int         dur;
        logic [1:0] pb;
        logic       exp_q[$];
        logic       dirs[$];
        logic       gr;
        logic       lv;
        pb  = 2'($random(seed));
        ns  = (slots == 0) ? 1 : slots;
        dur = act ? int'(ACT_LEAD_US) + int'(SLOT_US) * ns
                  : int'(FIRST_SLOT_US) + int'(SLOT_US) * (ns - 1)
                    + int'(DATA_US) + int'(REQ_DROP_US);
        dur = dur * int'(CYC_PER_US);
        exp_q.push_back(act | pb[0]);
        exp_q.push_back(act | (two ? pb[1] : f));
        exp_q.push_back(act | f);
        dirs.push_back(f);
        repeat (ns - 1) dirs.push_back(n);
        gr = !(sl && ns > 1 && !dirs[ns-2] && dirs[ns-1]);
        while (ready !== 1'b1)
            @(negedge clk_sys);
        {activity_scheme, two_bit_priority, first_dir_tx} = {act, two, f};
        {next_dir_tx, slow, busy_hold} = {n, sl, hd};
        priority_bits = pb;
        slot_count    = 8'(slots);
        start         = 1'b1;
        @(negedge clk_sys);
        start         = 1'b0;
        priority_bits = ~pb;
        cyc           = 1;
        nseen         = 0;
        while (done !== 1'b1 && cyc < 40000)
        begin
            @(negedge clk_sys);
            cyc++;
            if (slot_start === 1'b1)
                nseen++;
            lv = act ? peer_radio_priority : peer_radio_state_line;
            if (cyc % 200 == 100 && cyc < 600)
                check("link", lv, exp_q.pop_front());
        end
        check("duration", 16'(cyc >= dur - 40 && cyc <= dur + 40), 1);
        check("slots", 16'(nseen), 16'(ns));
        check("idle", {peer_radio_request, peer_radio_priority}, 0);
        if (act)
            check("busy_seen", wlan_busy_seen, hd);
        else
            check("granted", slot_granted, gr);
        $display("test done act %0d slots %0d", act, ns);
    endtask

    // cycle ceiling
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 100000)
        begin
            bad_count++;
            complete_run();
        end
    end

    // reset, then the scenarios
    initial
    begin
        {clk_sys, reset_n, start, activity_scheme, two_bit_priority} = 0;
        {first_dir_tx, next_dir_tx, priority_bits, slot_count} = 0;
        {slow, busy_hold, cycles, bad_count, checked} = 0;
        seed = 32'hf6b7;
        repeat (6) @(negedge clk_sys);
        reset_n = 1'b1;
        repeat (4) @(negedge clk_sys);
        check("reset_idle", {ready, peer_radio_request}, 2'b10);
        check("grant_idle", peer_slot_grant_n, 1'b1);
        run(1'b0, 1'b1, 1'b0, 1'b1, 2, 1'b1, 1'b0);
        run(1'b0, 1'b0, 1'b0, 1'b1, 1, 1'b0, 1'b0);
        run(1'b1, 1'b0, 1'b0, 1'b0, 0, 1'b0, 1'b0);
        run(1'b1, 1'b1, 1'b1, 1'b1, 1, 1'b0, 1'b1);
        complete_run();
    end
endmodule

`default_nettype wire
